// >>> bench/line_loss_props.sv
// Port-level checks for the signal-loss monitor
`timescale 1ns/1ps
`default_nettype none
`include "line_loss_defs.svh"
module line_loss_props
   import line_loss_pkg::*;
(
   input wire logic       clk,
   input wire logic       reset,
   input wire logic [3:0] address,
   input wire logic [7:0] write_data,
   input wire logic       write_strobe,
   input wire logic       read_strobe,
   input wire logic [7:0] read_data,
   input wire rail_s      rx_rail_outputs,
   input wire logic       recovered_clock_out,
   input wire rail_s      tx_line_pair,
   input wire logic       signal_absent_pin,
   input wire logic       loss_interrupt,
   input wire logic [4:0] loss_threshold_code,
   input wire logic [6:0] q_level_db
);
   // ****************
   // Control shadow
   // ****************
   logic [7:0] ctl;
   logic       status_rd;
   logic [4:0] code_req;
   assign code_req = (write_data[4:0] > `THRESHOLD_CLAMP) ?
                     `THRESHOLD_CLAMP : write_data[4:0];
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctl <= `CONTROL_RESET;
         status_rd <= 1'b0;
      end else begin
         status_rd <= read_strobe && address == `REG_STATUS;
         if (write_strobe && address == `REG_CONTROL) begin
            ctl <= write_data;
         end
      end
   end
   // ****************
   // Assertions
   // ****************
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   sequence s_rx_fill;
      (signal_absent_pin && ctl[`CTL_RX_ALL_ONES]) [*3];
   endsequence
   sequence s_tx_fill;
      (signal_absent_pin && ctl[`CTL_TX_ALL_ONES]) [*6];
   endsequence
   sequence s_code_write;
      write_strobe && address == `REG_THRESHOLD ##2 1'b1;
   endsequence
   a_rx_ones_fill: assert property (
      s_rx_fill |-> rx_rail_outputs == 2'b10)
      else $error("rx rails not all ones in loss");
   a_rx_master_clock: assert property (
      s_rx_fill |-> recovered_clock_out != $past(recovered_clock_out))
      else $error("rx clock not from master clock in loss");
   a_tx_ones_fill: assert property (
      s_tx_fill |-> (tx_line_pair | $past(tx_line_pair) |
         $past(tx_line_pair, 2) | $past(tx_line_pair, 3)) != 2'b00)
      else $error("tx line idle during loss fill");
   a_irq_masked: assert property (
      loss_interrupt |-> !$past(ctl[`CTL_LOSS_MASK]))
      else $error("interrupt high while masked");
   a_irq_on_loss: assert property (
      $rose(signal_absent_pin) && !ctl[`CTL_LOSS_MASK]
      |-> ##[0:2] loss_interrupt)
      else $error("no interrupt on loss");
   a_alarm_needs_cdr: assert property (
      status_rd && !$past(ctl[`CTL_CDR_ENABLE], 2)
      |-> !read_data[`STS_ALARM])
      else $error("alarm status with recovery off");
   a_code_clamped: assert property (
      s_code_write |-> loss_threshold_code == $past(code_req, 2))
      else $error("threshold code not clamped");
   a_q_from_code: assert property (
      $stable(loss_threshold_code) |-> q_level_db ==
         `Q_DB_BASE - {1'b0, loss_threshold_code, 1'b0})
      else $error("level dB does not follow code");
endmodule
`default_nettype wire

// >>> bench/line_rx_model.sv
// Line receiver model: recovered bit clock, rail marks, level flags
`timescale 1ns/1ps
`default_nettype none
module line_rx_model
   import line_loss_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic [1:0] mode,
   input  wire logic       level_good,
   output logic            rx_bit_clock,
   output rail_s           rx_line_pair,
   output logic            level_above_q,
   output logic            level_above_p
);
   // ****************
   // Bit clock at clk/8, marks by mode
   // ****************
   logic [2:0] phase;
   logic [3:0] bit_count;
   logic       polarity;
   logic       mark;
   assign mark = (mode == 2'd1) ||
                 (mode == 2'd2 && bit_count[1:0] == 2'd0) ||
                 (mode == 2'd3 && bit_count == 4'd0);
   assign level_above_q = level_good;
   assign level_above_p = level_good;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         phase <= 3'd0;
         bit_count <= 4'd0;
         polarity <= 1'b0;
         rx_bit_clock <= 1'b0;
         rx_line_pair <= 2'b00;
      end else begin
         phase <= phase + 3'd1;
         rx_bit_clock <= phase[2];
         // Data moves on the falling bit clock, AMI polarity
         if (phase == 3'd0) begin
            bit_count <= bit_count + 4'd1;
            polarity <= polarity ^ mark;
            rx_line_pair <= mark ? {polarity, !polarity} : 2'b00;
         end
      end
   end
endmodule
`default_nettype wire

// >>> bench/line_signal_loss_alarm_detect_tb_top.sv
// Self-checking bench for the signal-loss and alarm monitor
`timescale 1ns/1ps
`default_nettype none
`include "line_loss_defs.svh"
module line_signal_loss_alarm_detect_tb_top
   import line_loss_pkg::*;
;
   logic       clk = 1'b0;
   logic       reset = 1'b1;
   logic [3:0] address = 4'h0;
   logic [7:0] write_data = 8'h00;
   logic       write_strobe = 1'b0;
   logic       read_strobe = 1'b0;
   rail_s      tx_data = 2'b01;
   logic [1:0] loopback_mode = 2'h0;
   logic [1:0] mode = 2'h1;
   logic       level_good = 1'b1;
   logic       rx_bit_clock, level_above_q, level_above_p;
   rail_s      rx_line_pair, rx_rail_outputs, tx_line_pair;
   logic [7:0] read_data;
   logic       recovered_clock_out, signal_absent_pin, loss_interrupt;
   logic [4:0] loss_threshold_code;
   logic [6:0] q_level_db;
   int         mismatches = 0;
   int         total_checks = 0;
   int         cycles = 0;
   logic [4:0] codes [4] = '{5'h00, 5'h01, 5'h16, 5'h1f};
   logic [7:0] ctls [4] = '{8'h1c, 8'h31, 8'h13, 8'h12};
   int         decl [4] = '{32, 175, 1544, 2048};
   int         win [4] = '{32, 128, 128, 32};

   line_signal_loss_alarm_detect DUT (
      .clk(clk), .reset(reset), .address(address),
      .write_data(write_data), .write_strobe(write_strobe),
      .read_strobe(read_strobe), .read_data(read_data),
      .rx_bit_clock(rx_bit_clock), .rx_line_pair(rx_line_pair),
      .level_above_q(level_above_q), .level_above_p(level_above_p),
      .tx_data(tx_data), .loopback_mode(loopback_mode),
      .rx_rail_outputs(rx_rail_outputs),
      .recovered_clock_out(recovered_clock_out),
      .tx_line_pair(tx_line_pair), .signal_absent_pin(signal_absent_pin),
      .loss_interrupt(loss_interrupt),
      .loss_threshold_code(loss_threshold_code), .q_level_db(q_level_db));
   line_rx_model rx_model (
      .clk(clk), .reset(reset), .mode(mode), .level_good(level_good),
      .rx_bit_clock(rx_bit_clock), .rx_line_pair(rx_line_pair),
      .level_above_q(level_above_q), .level_above_p(level_above_p));

   // ****************
   // Clock, timeout, shared tasks
   // ****************
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         mismatches = mismatches + 1;
         conclude();
      end
   end
   task automatic conclude;
      if (mismatches == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      address <= a;
      write_data <= d;
      write_strobe <= 1'b1;
      @(posedge clk);
      write_strobe <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      address <= a;
      read_strobe <= 1'b1;
      @(posedge clk);
      read_strobe <= 1'b0;
      #1 check(read_data, exp);
   endtask
   task automatic bits(input int n);
      repeat (n) @(posedge rx_bit_clock);
      repeat (7) @(posedge clk);
   endtask
   task automatic pin(input logic e);
      #1 check(8'(signal_absent_pin), 8'(e));
   endtask

   // ****************
   // Scenarios
   // ****************
   task automatic alarm;
      bits(600);
      rd(`REG_STATUS, 8'h00);
      bits(500);
      rd(`REG_STATUS, 8'h02);
      wr(`REG_CONTROL, 8'h00);
      rd(`REG_STATUS, 8'h00);
      wr(`REG_CONTROL, 8'h12);
      bits(600);
      rd(`REG_STATUS, 8'h02);
      mode <= 2'd2;
      bits(600);
      rd(`REG_STATUS, 8'h00);
      mode <= 2'd1;
   endtask
   task automatic threshold;
      logic [4:0] e;
      for (int i = 0; i < 4; i++) begin
         e = (codes[i] > 5'h16) ? 5'h16 : codes[i];
         wr(`REG_THRESHOLD, {3'h0, codes[i]});
         repeat (2) @(posedge clk);
         #1 check(8'(loss_threshold_code), {3'h0, e});
         check(8'(q_level_db), 8'(`Q_DB_BASE - {1'b0, e, 1'b0}));
      end
   endtask
   task automatic loss_cycle(input int i);
      wr(`REG_CONTROL, ctls[i]);
      loopback_mode <= ctls[i][1:0];
      @(posedge rx_bit_clock);
      mode <= 2'd0;
      bits(decl[i] - 1);
      pin(1'b0);
      bits(1);
      pin(1'b1);
      check(8'(loss_interrupt), 8'(!ctls[i][5]));
      if (ctls[i][2]) begin
         check(8'(rx_rail_outputs), 8'h02);
      end
      if (!ctls[i][3]) begin
         check(8'(tx_line_pair), 8'(tx_data));
      end
      rd(`REG_EVENT, 8'h01);
      wr(`REG_EVENT, 8'h01);
      rd(`REG_EVENT, 8'h00);
      @(posedge rx_bit_clock);
      mode <= 2'd1;
      bits(win[i] - 1);
      pin(1'b1);
      bits(1);
      pin(1'b0);
   endtask
   task automatic density;
      wr(`REG_CONTROL, 8'h10);
      mode <= 2'd0;
      bits(40);
      level_good <= 1'b0;
      mode <= 2'd1;
      bits(64);
      pin(1'b1);
      level_good <= 1'b1;
      mode <= 2'd3;
      bits(96);
      pin(1'b1);
      mode <= 2'd2;
      bits(48);
      pin(1'b0);
   endtask

   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      rd(`REG_CONTROL, 8'h10);
      rd(`REG_THRESHOLD, 8'h15);
      rd(`REG_STATUS, 8'h00);
      wr(4'hf, 8'hff);
      rd(4'hf, 8'h00);
      alarm();
      threshold();
      for (int i = 0; i < 4; i++) begin
         loss_cycle(i);
      end
      density();
      conclude();
   end
endmodule

bind line_signal_loss_alarm_detect line_loss_props props (
   .clk(clk), .reset(reset), .address(address), .write_data(write_data),
   .write_strobe(write_strobe), .read_strobe(read_strobe),
   .read_data(read_data), .rx_rail_outputs(rx_rail_outputs),
   .recovered_clock_out(recovered_clock_out), .tx_line_pair(tx_line_pair),
   .signal_absent_pin(signal_absent_pin), .loss_interrupt(loss_interrupt),
   .loss_threshold_code(loss_threshold_code), .q_level_db(q_level_db));
`default_nettype wire

// >>> core/line_loss_defs.svh
// Constants for the signal-loss and alarm-indication monitor
`ifndef LINE_LOSS_DEFS_SVH
`define LINE_LOSS_DEFS_SVH

// Register addresses (plain port, 4-bit address, 8-bit data)
`define REG_CONTROL        4'h0
`define REG_THRESHOLD      4'h1
`define REG_STATUS         4'h2
`define REG_EVENT          4'h3

// Control register layout and reset value
`define CTL_STANDARD       0
`define CTL_CRITERIA       1
`define CTL_RX_ALL_ONES    2
`define CTL_TX_ALL_ONES    3
`define CTL_CDR_ENABLE     4
`define CTL_LOSS_MASK      5
`define CTL_LONG_HAUL      6
`define CONTROL_RESET      8'h10

// Threshold code, reset 10101 = -46 dB
`define THRESHOLD_RESET    5'h15
`define THRESHOLD_CLAMP    5'h16
`define Q_DB_BASE          7'h7c
`define Q_DB_STEP          7'h02

// Status and event bits
`define STS_SIGNAL_ABSENT  0
`define STS_ALARM          1
`define EVT_LOSS           0

// Declare counts N in bit periods
`define N_T1_STD           12'd175
`define N_T1_ALT           12'd1544
`define N_E1_STD           12'd32
`define N_E1_ALT           12'd2048

// Clear windows M and consecutive-zero limits
`define M_T1               8'd128
`define M_E1               8'd32
`define ZLIM_T1            7'd100
`define ZLIM_E1            7'd16
`define DENSITY_SHIFT      3

// Alarm indication blocks
`define AIS_E1_BLOCK       14'd512
`define AIS_T1_BLOCK       14'd8192
`define AIS_E1_ZEROS       4'd3
`define AIS_T1_ZEROS       4'd9
`define AIS_T1_WINDOW_US   5300

`endif

// >>> core/line_loss_pkg.sv
// Types shared by the signal-loss monitor
package line_loss_pkg;

   typedef struct packed {
      logic pos;
      logic neg;
   } rail_s;

   typedef struct packed {
      logic long_haul;
      logic loss_mask;
      logic cdr_enable;
      logic tx_all_ones;
      logic rx_all_ones;
      logic criteria;
      logic standard;
   } config_s;

   typedef enum logic [1:0] {
      ST_PRESENT = 2'b00,
      ST_ABSENT  = 2'b01,
      ST_QUALIFY = 2'b10
   } loss_state_e;

endpackage

// >>> core/line_signal_loss_alarm_detect.sv
// Signal-loss and alarm-indication monitor for one receive channel
//
// What this block does
// - After N bit periods with no pulse, declare loss, pin high, flag event.
// - Clear loss after M-bit window from pulse with level and 12.5% density.
// - T1/J1: N is 175 bits, or 1544 with criteria-select set.
// - E1: N is 32 bits, or 2048 with criteria-select set.
// - T1/J1 clearing: window 128 bits, fewer than 100 consecutive zeros.
// - E1 clearing: window 32 bits, fewer than 16 consecutive zeros.
// - Standard select (1 T1/J1, 0 E1) and criteria-select pick the criteria.
// - Long haul: 5-bit code gives Q from -4 dB in 2 dB steps, max -48.
// - During loss, rails follow input, or all ones with master clock out.
// - Transmit all-ones-on-loss sends all-ones on line from master clock.
// - Loss indication works regardless of any loopback setting.
// - Alarm detection only with clock recovery on; result in status bit.
// - E1 standard: under 3 zeros in two 512-bit blocks declares; 3+ clears.
// - E1 alternate: one 512-bit block with 3 or more zeros clears.
// - T1/J1: 99.9% ones over 5.3 ms declares; 9 zeros in 8192 bits clears.
// - Criteria-select resets to 0.
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "line_loss_defs.svh"

module line_signal_loss_alarm_detect
   import line_loss_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [3:0]  address,
   input  wire logic [7:0]  write_data,
   input  wire logic        write_strobe,
   input  wire logic        read_strobe,
   output logic      [7:0]  read_data,
   input  wire logic        rx_bit_clock,
   input  wire rail_s       rx_line_pair,
   input  wire logic        level_above_q,
   input  wire logic        level_above_p,
   input  wire rail_s       tx_data,
   input  wire logic [1:0]  loopback_mode,
   output rail_s            rx_rail_outputs,
   output logic             recovered_clock_out,
   output rail_s            tx_line_pair,
   output logic             signal_absent_pin,
   output logic             loss_interrupt,
   output logic [4:0]       loss_threshold_code,
   output logic [6:0]       q_level_db
);

   // ************************************************************
   // Helper functions
   // ************************************************************
   function automatic logic [11:0] declare_n(input logic std,
                                             input logic crit);
      if (std)
         declare_n = crit ? `N_T1_ALT : `N_T1_STD;
      else
         declare_n = crit ? `N_E1_ALT : `N_E1_STD;
   endfunction

   function automatic logic [7:0] window_m(input logic std);
      window_m = std ? `M_T1 : `M_E1;
   endfunction

   function automatic logic [6:0] zero_limit(input logic std);
      zero_limit = std ? `ZLIM_T1 : `ZLIM_E1;
   endfunction

   function automatic logic [4:0] clamp_code(input logic [4:0] code);
      clamp_code = (code >= `THRESHOLD_CLAMP) ? `THRESHOLD_CLAMP : code;
   endfunction

   function automatic logic [6:0] level_db(input logic [4:0] code);
      logic [4:0] c;
      c = clamp_code(code);
      level_db = `Q_DB_BASE - `Q_DB_STEP * {2'b00, c};
   endfunction

   // ************************************************************
   // Registers
   // ************************************************************
   config_s     cfg;
   logic [4:0]  threshold;
   logic        loss_event;
   logic        signal_absent;
   logic        alarm_indication_status;

   wire wr_control   = write_strobe && address == `REG_CONTROL;
   wire wr_threshold = write_strobe && address == `REG_THRESHOLD;
   wire wr_event     = write_strobe && address == `REG_EVENT;
   wire loss_rise;

   wire [7:0] status_word = {6'h00, alarm_indication_status, signal_absent};
   wire [7:0] read_mux =
      (address == `REG_CONTROL)   ? {1'b0, cfg} :
      (address == `REG_THRESHOLD) ? {3'b000, threshold} :
      (address == `REG_STATUS)    ? status_word :
      (address == `REG_EVENT)     ? {7'h00, loss_event} : 8'h00;

   // A new declare wins over a clear in the same cycle
   wire next_loss_event = loss_rise ||
      (loss_event && !(wr_event && write_data[`EVT_LOSS]));

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg       <= config_s'(7'(`CONTROL_RESET));
         threshold <= `THRESHOLD_RESET;
         read_data <= 8'h00;
      end else begin
         if (wr_control)
            cfg <= config_s'(write_data[6:0]);
         if (wr_threshold)
            threshold <= write_data[4:0];
         // Read data stands one cycle, zero otherwise
         read_data <= read_strobe ? read_mux : 8'h00;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         loss_event     <= 1'b0;
         loss_interrupt <= 1'b0;
      end else begin
         loss_event     <= next_loss_event;
         loss_interrupt <= next_loss_event && !cfg.loss_mask;
      end
   end

   // ************************************************************
   // Input synchronisers and bit timing
   // ************************************************************
   logic [4:0] sync1;
   logic [4:0] sync2;
   logic       bit_clock_prev;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync1          <= 5'h00;
         sync2          <= 5'h00;
         bit_clock_prev <= 1'b0;
      end else begin
         sync1 <= {level_above_p, level_above_q, rx_line_pair,
                   rx_bit_clock};
         sync2          <= sync1;
         bit_clock_prev <= sync2[0];
      end
   end

   // Bit clock edge seen two clocks late; rails sampled with it
   wire  bit_clock_s = sync2[0];
   wire  bit_tick    = bit_clock_s && !bit_clock_prev;
   wire  rx_pos_s    = sync2[2];
   wire  rx_neg_s    = sync2[1];
   wire  above_q_s   = cfg.long_haul ? sync2[3] : sync2[3];
   wire  above_p_s   = sync2[4];
   wire  mark        = rx_pos_s || rx_neg_s;
   // Marks below the declare level count as no pulse
   wire  pulse_q     = mark && above_q_s;
   wire  pulse_p     = mark && above_p_s;

   // ************************************************************
   // Loss declare and clear
   // ************************************************************
   loss_state_e state;
   loss_state_e next_state;
   logic [11:0] gap_count;
   logic [7:0]  win_count;
   logic [7:0]  mark_count;
   logic [6:0]  zero_run;
   logic        win_fail;

   wire [11:0] n_bits   = declare_n(cfg.standard, cfg.criteria);
   wire [7:0]  m_bits   = window_m(cfg.standard);
   wire [6:0]  z_limit  = zero_limit(cfg.standard);
   wire        gap_full = &gap_count;
   wire [11:0] next_gap = pulse_q  ? 12'h000 :
                          gap_full ? gap_count : gap_count + 12'h001;
   wire        gap_hit  = bit_tick && !pulse_q && next_gap >= n_bits;
   wire [7:0]  next_win = win_count + 8'h01;
   wire [7:0]  next_mk  = mark_count + {7'h00, pulse_p};
   wire [6:0]  next_zr  = pulse_p ? 7'h00 : zero_run + 7'h01;
   wire        zr_bad   = !pulse_p && next_zr >= z_limit;
   wire        win_end  = bit_tick && next_win >= m_bits;
   wire        dense_ok = ({next_mk, `DENSITY_SHIFT'(0)} >=
                           {3'b000, m_bits});
   wire        win_pass = win_end && !win_fail && !zr_bad
                          && above_p_s && dense_ok;

   assign loss_rise = (state == ST_PRESENT) && gap_hit;

   always_comb begin
      next_state = state;
      case (state)
         ST_PRESENT: if (gap_hit) next_state = ST_ABSENT;
         ST_ABSENT:  if (bit_tick && pulse_p)
                        next_state = ST_QUALIFY;
         ST_QUALIFY: if (win_pass)
                        next_state = ST_PRESENT;
                     else if (win_end)
                        next_state = ST_ABSENT;
         default:    next_state = ST_ABSENT;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         gap_count <= 12'h000;
      end else if (bit_tick) begin
         gap_count <= next_gap;
      end
   end

   // A qualifying pulse opens the window as bit one
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state      <= ST_PRESENT;
         win_count  <= 8'h00;
         mark_count <= 8'h00;
         zero_run   <= 7'h00;
         win_fail   <= 1'b0;
      end else begin
         state <= next_state;
         if (bit_tick) begin
            if (state == ST_QUALIFY && !win_end) begin
               win_count  <= next_win;
               mark_count <= next_mk;
               zero_run   <= next_zr;
               win_fail   <= win_fail || zr_bad || !above_p_s;
            end else begin
               win_count  <= 8'h01;
               mark_count <= 8'h01;
               zero_run   <= 7'h00;
               win_fail   <= 1'b0;
            end
         end
      end
   end

   // Loopback setting is not an input to the loss path
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         signal_absent     <= 1'b0;
         signal_absent_pin <= 1'b0;
      end else begin
         signal_absent     <= next_state != ST_PRESENT;
         signal_absent_pin <= next_state != ST_PRESENT;
      end
   end

   // ************************************************************
   // Alarm indication detection
   // ************************************************************
   // An 8192-bit block needs a 14-bit count
   logic [13:0] blk_count;
   logic [3:0]  blk_zeros;
   logic        prev_few;

   wire [13:0] blk_len   = cfg.standard ? `AIS_T1_BLOCK : `AIS_E1_BLOCK;
   wire [3:0]  zero_need = cfg.standard ? `AIS_T1_ZEROS : `AIS_E1_ZEROS;
   wire [3:0]  next_bz   = (!mark && blk_zeros != 4'hf) ?
                           blk_zeros + 4'h1 : blk_zeros;
   wire        blk_end   = bit_tick && (blk_count + 14'h0001) >= blk_len;
   wire        few       = next_bz < zero_need;
   wire        two_block = !cfg.standard && !cfg.criteria;
   wire        ais_set   = few &&
                           (!two_block || prev_few);
   wire        ais_clr   = !few &&
                           (!two_block || !prev_few);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         blk_count               <= 14'h0000;
         blk_zeros               <= 4'h0;
         prev_few                <= 1'b0;
         alarm_indication_status <= 1'b0;
      end else if (!cfg.cdr_enable) begin
         blk_count               <= 14'h0000;
         blk_zeros               <= 4'h0;
         prev_few                <= 1'b0;
         alarm_indication_status <= 1'b0;
      end else if (blk_end) begin
         blk_count <= 14'h0000;
         blk_zeros <= 4'h0;
         prev_few  <= few;
         if (ais_set)
            alarm_indication_status <= 1'b1;
         else if (ais_clr)
            alarm_indication_status <= 1'b0;
      end else if (bit_tick) begin
         blk_count <= blk_count + 14'h0001;
         blk_zeros <= next_bz;
      end
   end

   // ************************************************************
   // All-ones substitution toward system and line
   // ************************************************************
   logic master_div;
   logic tx_polarity;

   wire lost       = state != ST_PRESENT;
   wire rx_sub     = lost && cfg.rx_all_ones;
   wire tx_sub     = lost && cfg.tx_all_ones;
   wire master_hi  = !master_div;
   wire [1:0] unused_loop = loopback_mode;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         master_div          <= 1'b0;
         tx_polarity         <= 1'b0;
         rx_rail_outputs     <= '0;
         recovered_clock_out <= 1'b0;
         tx_line_pair        <= '0;
         loss_threshold_code <= `THRESHOLD_RESET;
         q_level_db          <= level_db(`THRESHOLD_RESET);
      end else begin
         master_div <= !master_div;
         if (master_hi)
            tx_polarity <= !tx_polarity;
         if (rx_sub) begin
            rx_rail_outputs     <= '{pos: 1'b1, neg: 1'b0};
            recovered_clock_out <= master_hi;
         end else begin
            rx_rail_outputs     <= '{pos: rx_pos_s, neg: rx_neg_s};
            recovered_clock_out <= bit_clock_s;
         end
         // Alternate mark polarity on the all-ones fill
         if (tx_sub)
            tx_line_pair <= '{pos: master_hi && !tx_polarity,
                              neg: master_hi && tx_polarity};
         else
            tx_line_pair <= tx_data;
         loss_threshold_code <= clamp_code(threshold);
         q_level_db          <= level_db(threshold);
      end
   end

endmodule
`default_nettype wire
